// ### verilog/rcw_top.sv
// Reset cause recorder, reset sequencer and watchdog with AXI4-Lite registers
`default_nettype none

module rcw_top
  import rcw_pkg::*;
#(
  parameter int OSC_DIV  = OSC_DIV_DEF,   // Clocks per watchdog tick
  parameter int WDT_BASE = WDT_BASE_DEF,  // Ticks of shortest time-out
  parameter int RST_DLY  = RST_DLY_DEF    // Reset stretch in clocks
)(
  input  wire logic        CLOCK_IN,             // 25 MHz clock
  input  wire logic        RST_IN,               // Power-on reset
  input  wire logic [7:0]  AWADDR_IN,            // Write address
  input  wire logic        AWVALID_IN,           // Write address valid
  output logic             AWREADY_OUT,          // Write address ready
  input  wire logic [31:0] WDATA_IN,             // Write data
  input  wire logic [3:0]  WSTRB_IN,             // Write strobes
  input  wire logic        WVALID_IN,            // Write data valid
  output logic             WREADY_OUT,           // Write data ready
  output logic [1:0]       BRESP_OUT,            // Write response
  output logic             BVALID_OUT,           // Write response valid
  input  wire logic        BREADY_IN,            // Write response ready
  input  wire logic [7:0]  ARADDR_IN,            // Read address
  input  wire logic        ARVALID_IN,           // Read address valid
  output logic             ARREADY_OUT,          // Read address ready
  output logic [31:0]      RDATA_OUT,            // Read data
  output logic [1:0]       RRESP_OUT,            // Read response
  output logic             RVALID_OUT,           // Read data valid
  input  wire logic        RREADY_IN,            // Read data ready
  input  wire logic [2:0]  BOD_LEVEL_FUSE_IN,    // Brownout level fuse
  input  wire logic        WDT_ALWAYS_ON_FUSE_IN,// Watchdog always-on fuse
  input  wire logic        SUPPLY_LOW_IN,        // Detector: supply low
  input  wire logic        PIN_RESET_N_IN,       // Reset pin, active low
  input  wire logic        SCAN_RESET_IN,        // Scan reset register bit
  input  wire logic        USB_ENABLE_IN,        // USB controller enabled
  input  wire logic        USB_RESET_CPU_IN,     // Reset core on bus reset
  input  wire logic        USB_BUS_RESET_IN,     // Valid bus reset seen
  input  wire logic        COMP_BANDGAP_SEL_IN,  // Comparator uses bandgap
  input  wire logic        ADC_ENABLE_IN,        // ADC enabled
  input  wire logic        WDT_RESTART_IN,       // Restart instruction
  input  wire logic        WDT_VECTOR_ACK_IN,    // Watchdog vector entered
  output logic             CORE_RESET_OUT,       // Core held in reset
  output logic             BOD_ENABLE_OUT,       // Brownout detector on
  output logic [2:0]       BOD_LEVEL_OUT,        // Trigger level code
  output logic             BANDGAP_EN_OUT,       // Bandgap reference on
  output logic             WDT_IRQ_OUT,          // Watchdog interrupt
  output logic             WDT_RESET_PULSE_OUT   // One-clock dog reset
);

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]           meta_r;
  logic [2:0]           sync_r;
  logic [2:0]           bod_level_r;
  logic                 watchdog_always_on_fuse_r;
  logic                 bod_en_r;
  logic                 bg_r;
  logic                 core_rst_r;
  logic [15:0]          dly_cnt_r;
  logic [15:0]          div_cnt_r;
  logic                 tick_r;
  logic [WDT_CNT_W-1:0] wdt_cnt_r;
  logic                 wdt_pulse_r;
  logic                 irq_r;
  logic [CAUSE_W-1:0]   cause_r;
  logic [2:0]           ce_cnt_r;
  logic                 wde_r;
  logic                 watchdog_irq_enable_r;
  logic                 watchdog_irq_flag_r;
  logic [3:0]           wdp_r;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [7:0]           waddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 supply_low;
  logic                 pin_rst;
  logic                 scan_rst;
  logic                 bod_rst;
  logic                 usb_rst;
  logic                 any_src;
  logic                 wde_eff;
  logic                 win_open;
  rcw_mode_e            mode;
  logic [3:0]           wdp_sel;
  logic [WDT_CNT_W-1:0] limit;
  logic                 expire;
  logic                 irq_set;
  logic                 wr_fire;
  logic                 wr_cause;
  logic                 wr_wctl;
  logic [7:0]           wd;
  logic [3:0]           wd_wdp;
  logic [CAUSE_W-1:0]   cause_set;
  logic [CAUSE_W-1:0]   cause_clr;
  logic [31:0]          rd_mux;
  logic                 rd_hit;

  // ----------------------------------------------------------------
  // Pin synchronisers and fuse capture
  // ----------------------------------------------------------------
  // Two flops per asynchronous pin; only the second is read
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge CLOCK_IN)
      begin
        if (RST_IN)
        begin
          meta_r[gi] <= SYNC_IDLE[gi];
          sync_r[gi] <= SYNC_IDLE[gi];
        end
        else
        begin
          meta_r[gi] <= (gi == 0) ? SUPPLY_LOW_IN : (gi == 1) ? PIN_RESET_N_IN : SCAN_RESET_IN;
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign supply_low = sync_r[0];
  assign pin_rst    = !sync_r[1];
  assign scan_rst   = sync_r[2];

  // Fuses are static; caught while power-on reset is held
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      bod_level_r <= BOD_LEVEL_FUSE_IN;
      watchdog_always_on_fuse_r     <= WDT_ALWAYS_ON_FUSE_IN;
    end
  end

  // Detector enable and bandgap demand
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      bod_en_r <= 1'b0;
      bg_r     <= 1'b0;
    end
    else
    begin
      bod_en_r <= (bod_level_r != BOD_OFF);
      bg_r     <= bod_en_r | COMP_BANDGAP_SEL_IN | ADC_ENABLE_IN;
    end
  end

  // ----------------------------------------------------------------
  // Reset sources and delay counter
  // ----------------------------------------------------------------
  assign bod_rst = bod_en_r & supply_low;
  assign usb_rst = USB_ENABLE_IN & USB_RESET_CPU_IN & USB_BUS_RESET_IN;
  assign any_src = bod_rst | pin_rst | scan_rst | usb_rst | wdt_pulse_r;

  // Counter reloads while any source is active, so it only starts
  // running once the last one has gone away
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || any_src)
    begin
      core_rst_r <= 1'b1;
      dly_cnt_r  <= 16'(RST_DLY);
    end
    else if (dly_cnt_r != 16'h0000)
      dly_cnt_r <= dly_cnt_r - 16'h0001;
    else
      core_rst_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Watchdog oscillator tick and counter
  // ----------------------------------------------------------------
  // Tick enable stands in for the separate slow oscillator
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || div_cnt_r == 16'(OSC_DIV - 1))
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
    tick_r <= !RST_IN && (div_cnt_r == 16'(OSC_DIV - 1));
  end

  // Mode decode; the cause flag and fuse both pin reset-enable
  assign wde_eff = wde_r | cause_r[CF_DOG] | watchdog_always_on_fuse_r;
  always_comb
  begin
    case ({wde_eff, watchdog_irq_enable_r})
      2'b01:   mode = WM_IRQ;
      2'b10:   mode = WM_RST;
      2'b11:   mode = WM_BOTH;
      default: mode = WM_STOP;
    endcase
  end

  // Reserved prescale codes behave as the longest time-out
  assign wdp_sel = (wdp_r > 4'(WDP_MAX)) ? 4'(WDP_MAX) : wdp_r;
  assign limit   = WDT_CNT_W'(WDT_BASE) << wdp_sel;
  assign expire  = tick_r && (wdt_cnt_r == limit - WDT_CNT_W'(1));
  assign irq_set = expire && (mode == WM_IRQ || (mode == WM_BOTH && !watchdog_irq_flag_r));

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || core_rst_r || WDT_RESTART_IN || mode == WM_STOP || expire)
      wdt_cnt_r <= '0;
    else if (tick_r)
      wdt_cnt_r <= wdt_cnt_r + WDT_CNT_W'(1);
  end

  // Combined mode resets only when the interrupt went unserviced
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
      wdt_pulse_r <= 1'b0;
    else
      wdt_pulse_r <= expire && (mode == WM_RST || (mode == WM_BOTH && watchdog_irq_flag_r));
  end

  // Interrupt line doubles as the wake request
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
      irq_r <= 1'b0;
    else
      irq_r <= watchdog_irq_flag_r & watchdog_irq_enable_r;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_fire  = aw_got_r && w_got_r && !BVALID_OUT;
  assign wr_cause = wr_fire && waddr_r == ADDR_CAUSE && wstrb_r[0];
  assign wr_wctl  = wr_fire && waddr_r == ADDR_WCTL && wstrb_r[0];
  assign wd       = wdata_r[7:0];
  assign wd_wdp   = {wd[WC_P3], wd[2:0]};
  assign win_open = (ce_cnt_r != 3'h0);

  // Cause flags: sources set, written zeros clear, set wins
  assign cause_set = {usb_rst, scan_rst, wdt_pulse_r, bod_rst, pin_rst, 1'b0};
  assign cause_clr = wr_cause ? ~wd[CAUSE_W-1:0] : '0;
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
      cause_r <= CAUSE_POR;
    else
      cause_r <= (cause_r & ~cause_clr) | cause_set;
  end

  // Change window opens only on the combined unlock write
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || core_rst_r)
      ce_cnt_r <= 3'h0;
    else if (wr_wctl && wd[WC_CE] && wd[WC_DE])
      ce_cnt_r <= 3'(WATCHDOG_CHANGE_ENABLE_CYC);
    else if (win_open)
      ce_cnt_r <= ce_cnt_r - 3'h1;
  end

  // Protected fields; setting reset-enable is always allowed
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || core_rst_r)
    begin
      wde_r <= 1'b0;
      wdp_r <= 4'h0;
    end
    else if (wr_wctl && win_open && !wd[WC_CE])
    begin
      wde_r <= wd[WC_DE];
      wdp_r <= wd_wdp;
    end
    else if (wr_wctl && wd[WC_DE])
      wde_r <= 1'b1;
  end

  // Interrupt enable and flag; hardware set beats a clear
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN || core_rst_r)
    begin
      watchdog_irq_enable_r <= 1'b0;
      watchdog_irq_flag_r <= 1'b0;
    end
    else
    begin
      if (watchdog_always_on_fuse_r || (WDT_VECTOR_ACK_IN && mode == WM_BOTH))
        watchdog_irq_enable_r <= 1'b0;
      else if (wr_wctl)
        watchdog_irq_enable_r <= wd[WC_IE];
      if (irq_set)
        watchdog_irq_flag_r <= 1'b1;
      else if (WDT_VECTOR_ACK_IN || (wr_wctl && wd[WC_IF]))
        watchdog_irq_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data taken in either order, answer after both
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      aw_got_r    <= 1'b0;
      w_got_r     <= 1'b0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= RESP_OK;
    end
    else
    begin
      // Ready rises at the response handshake and drops at a take
      AWREADY_OUT <= (BVALID_OUT && BREADY_IN) || (!aw_got_r && !(AWVALID_IN && AWREADY_OUT));
      WREADY_OUT  <= (BVALID_OUT && BREADY_IN) || (!w_got_r && !(WVALID_IN && WREADY_OUT));
      if (AWVALID_IN && AWREADY_OUT)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT)
      begin
        w_got_r <= 1'b1;
        wdata_r <= WDATA_IN;
        wstrb_r <= WSTRB_IN;
      end
      if (wr_fire)
      begin
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= (waddr_r == ADDR_CAUSE || waddr_r == ADDR_WCTL) ? RESP_OK : RESP_ERR;
      end
      else if (BVALID_OUT && BREADY_IN)
      begin
        BVALID_OUT <= 1'b0;
        aw_got_r   <= 1'b0;
        w_got_r    <= 1'b0;
      end
    end
  end

  // Read mux; bits above each register read zero
  always_comb
  begin
    rd_hit = 1'b1;
    case (ARADDR_IN)
      ADDR_CAUSE: rd_mux = {{(32 - CAUSE_W){1'b0}}, cause_r};
      ADDR_WCTL:  rd_mux = {24'h0, watchdog_irq_flag_r, watchdog_irq_enable_r, wdp_r[3], win_open, wde_eff, wdp_r[2:0]};
      ADDR_STAT:  rd_mux = {27'h0, core_rst_r, bg_r, bod_en_r, mode};
      default:
      begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0;
      RRESP_OUT   <= RESP_OK;
    end
    else if (ARVALID_IN && ARREADY_OUT)
    begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b1;
      RDATA_OUT   <= rd_mux;
      RRESP_OUT   <= rd_hit ? RESP_OK : RESP_ERR;
    end
    else if (RVALID_OUT && RREADY_IN)
    begin
      RVALID_OUT  <= 1'b0;
      ARREADY_OUT <= 1'b1;
    end
    else if (!RVALID_OUT)
      ARREADY_OUT <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  assign CORE_RESET_OUT      = core_rst_r;
  assign BOD_ENABLE_OUT      = bod_en_r;
  assign BOD_LEVEL_OUT       = bod_level_r;
  assign BANDGAP_EN_OUT      = bg_r;
  assign WDT_IRQ_OUT         = irq_r;
  assign WDT_RESET_PULSE_OUT = wdt_pulse_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bod_off;
    (bod_level_r == BOD_OFF) |=> !bod_en_r;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("brownout on with off code");

  property p_bod_rst;
    bod_rst |=> core_rst_r && cause_r[CF_SUP];
  endproperty
  a_bod_rst: assert property (p_bod_rst) else $error("brownout reset missed");

  property p_hold;
    (!any_src && dly_cnt_r != 16'h0000) |=> core_rst_r;
  endproperty
  a_hold: assert property (p_hold) else $error("core released early");

  property p_pulse;
    wdt_pulse_r |=> !wdt_pulse_r && core_rst_r && dly_cnt_r == 16'(RST_DLY);
  endproperty
  a_pulse: assert property (p_pulse) else $error("watchdog pulse wrong");

  property p_usb;
    usb_rst |=> core_rst_r && cause_r[CF_USB];
  endproperty
  a_usb: assert property (p_usb) else $error("usb reset missed");

  property p_pwr_keep;
    (cause_r[CF_PWR] && !(wr_cause && !wd[CF_PWR])) |=> cause_r[CF_PWR];
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("power flag lost");

  property p_restart;
    WDT_RESTART_IN |=> wdt_cnt_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");

  property p_fuse;
    watchdog_always_on_fuse_r |=> !watchdog_irq_enable_r && wde_eff;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse not forcing reset mode");

  property p_win_write;
    (wr_wctl && win_open && !wd[WC_CE] && !core_rst_r) |=> wdp_r == $past(wd_wdp);
  endproperty
  a_win_write: assert property (p_win_write) else $error("window write lost");

  property p_ce_close;
    (ce_cnt_r == 3'(WATCHDOG_CHANGE_ENABLE_CYC)) |-> ##4 (ce_cnt_r == 3'h0 || ce_cnt_r == 3'(WATCHDOG_CHANGE_ENABLE_CYC));
  endproperty
  a_ce_close: assert property (p_ce_close) else $error("window stayed open");

  property p_locked;
    (wr_wctl && !win_open) |=> $stable(wdp_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked prescale changed");

  c_dog_rst: cover property (wdt_pulse_r);
  c_irq:     cover property (irq_set && mode == WM_BOTH);
  c_usb:     cover property (usb_rst);
  c_window:  cover property (wr_wctl && win_open && !wd[WC_CE]);

endmodule

`default_nettype wire

// ### verilog/rcw_pkg.sv
// Constants, types and register map of the reset cause and watchdog block
// Behaviour
// - Fuse code picks brownout level; 111 disables
// - Enabled brownout asserts reset without delay
// - Brownout clear: hold reset for delay count
// - Watchdog reset pulse lasts one clock
// - Delay counter starts after watchdog pulse ends
// - USB bus reset resets core, not USB
// - Cause bits 7..6 read zero, never written
// - Bit 5 USB cause; power-up or zero clears
// - Bit 4 scan reset cause; same clearing
// - Bit 3 watchdog cause; same clearing
// - Bit 2 brownout cause; same clearing
// - Bit 1 pin reset cause; same clearing
// - Bit 0 set on power-up; only software clears
// - Bandgap on for brownout, comparator or ADC
// - Watchdog counts ticks of 128 kHz oscillator
// - Restart zeroes counter; expiry acts per mode
// - Interrupt mode raises wake-capable interrupt on expiry
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode, no interrupt
// - Protected values accepted only within four cycles
// - Time-out selectable from 16 ms to 8 s
// - Change-enable clears itself four cycles later
// - Watchdog cause flag forces reset-enable high
// - Combined mode vector entry clears enable and flag
`default_nettype none

package rcw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 25000000;
  localparam int WDT_OSC_HZ   = 128000;
  localparam int OSC_DIV_DEF  = CLK_HZ / WDT_OSC_HZ;
  localparam int WDT_MIN_MS   = 16;
  localparam int WDT_MAX_MS   = 8000;
  localparam int WDT_BASE_DEF = WDT_MIN_MS * WDT_OSC_HZ / 1000;
  localparam int WDP_MAX      = $clog2(WDT_MAX_MS / WDT_MIN_MS);
  localparam int WDT_CNT_W    = $clog2(WDT_BASE_DEF) + WDP_MAX + 1;
  localparam int RST_DLY_DEF  = 1024;
  localparam int WATCHDOG_CHANGE_ENABLE_CYC     = 4;

  // ----------------------------------------------------------------
  // Fuses, reset values and bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] BOD_OFF   = 3'h7;
  localparam logic [2:0] SYNC_IDLE = 3'h2;
  localparam int         CAUSE_W   = 6;
  localparam logic [5:0] CAUSE_POR = 6'h01;
  localparam int CF_USB  = 5;
  localparam int CF_SCAN = 4;
  localparam int CF_DOG  = 3;
  localparam int CF_SUP  = 2;
  localparam int CF_PIN  = 1;
  localparam int CF_PWR  = 0;
  localparam int WC_IF   = 7;
  localparam int WC_IE   = 6;
  localparam int WC_P3   = 5;
  localparam int WC_CE   = 4;
  localparam int WC_DE   = 3;

  // ----------------------------------------------------------------
  // Register map and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_WCTL  = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;

  typedef enum logic [1:0] {WM_STOP, WM_IRQ, WM_RST, WM_BOTH} rcw_mode_e;

endpackage

`default_nettype wire

// ### tb/rcw_top_bench.sv
// Self-checking bench for the reset cause and watchdog block
`default_nettype none

module rcw_top_bench
  import rcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------
  // Stimulus signals and design
  // --------------------------------------------------------------
  localparam int DLY  = 8; // Short reset stretch keeps the run brief
  localparam int OSC  = 4; // Clocks per watchdog tick
  localparam int BASE = 4; // Ticks of the shortest time-out
  logic        CLOCK_IN = 1'b0;
  logic        RST_IN, AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN;
  logic [7:0]  AWADDR_IN, ARADDR_IN;
  logic [31:0] WDATA_IN, RDATA_OUT, rdv;
  logic [3:0]  WSTRB_IN;
  logic [2:0]  BOD_LEVEL_FUSE_IN, BOD_LEVEL_OUT;
  logic        WDT_ALWAYS_ON_FUSE_IN, SUPPLY_LOW_IN, PIN_RESET_N_IN, SCAN_RESET_IN;
  logic        USB_ENABLE_IN, USB_RESET_CPU_IN, USB_BUS_RESET_IN, COMP_BANDGAP_SEL_IN;
  logic        ADC_ENABLE_IN, WDT_RESTART_IN, WDT_VECTOR_ACK_IN;
  logic        AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
  logic [1:0]  BRESP_OUT, RRESP_OUT, rsp;
  logic        CORE_RESET_OUT, BOD_ENABLE_OUT, BANDGAP_EN_OUT, WDT_IRQ_OUT;
  logic        WDT_RESET_PULSE_OUT;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          n;
  logic [31:0] src_exp [3] = '{32'h02, 32'h10, 32'h20};

  // Free-running 25 MHz clock
  always #20 CLOCK_IN = ~CLOCK_IN;

  rcw_top #(.OSC_DIV(OSC), .WDT_BASE(BASE), .RST_DLY(DLY)) i_dut (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN),
    .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN),
    .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT),
    .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN),
    .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
    .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN),
    .BOD_LEVEL_FUSE_IN(BOD_LEVEL_FUSE_IN), .WDT_ALWAYS_ON_FUSE_IN(WDT_ALWAYS_ON_FUSE_IN),
    .SUPPLY_LOW_IN(SUPPLY_LOW_IN), .PIN_RESET_N_IN(PIN_RESET_N_IN),
    .SCAN_RESET_IN(SCAN_RESET_IN), .USB_ENABLE_IN(USB_ENABLE_IN),
    .USB_RESET_CPU_IN(USB_RESET_CPU_IN), .USB_BUS_RESET_IN(USB_BUS_RESET_IN),
    .COMP_BANDGAP_SEL_IN(COMP_BANDGAP_SEL_IN), .ADC_ENABLE_IN(ADC_ENABLE_IN),
    .WDT_RESTART_IN(WDT_RESTART_IN), .WDT_VECTOR_ACK_IN(WDT_VECTOR_ACK_IN),
    .CORE_RESET_OUT(CORE_RESET_OUT), .BOD_ENABLE_OUT(BOD_ENABLE_OUT),
    .BOD_LEVEL_OUT(BOD_LEVEL_OUT), .BANDGAP_EN_OUT(BANDGAP_EN_OUT),
    .WDT_IRQ_OUT(WDT_IRQ_OUT), .WDT_RESET_PULSE_OUT(WDT_RESET_PULSE_OUT)
  );

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  // Compare and count; case inequality so an unknown never matches a known value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Response ready stays high afterwards, so each call's response handshake ends at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    AWADDR_IN <= a;
    WDATA_IN <= d;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    while (!done)
    begin
      @(posedge CLOCK_IN);
      if (AWREADY_OUT === 1'b1) AWVALID_IN <= 1'b0;
      if (WREADY_OUT === 1'b1) WVALID_IN <= 1'b0;
      if (BVALID_OUT === 1'b1) done = 1'b1;
    end
    rsp = BRESP_OUT;
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    while (!done)
    begin
      @(posedge CLOCK_IN);
      if (ARREADY_OUT === 1'b1) ARVALID_IN <= 1'b0;
      if (RVALID_OUT === 1'b1) done = 1'b1;
    end
    rsp = RRESP_OUT;
    rdv = RDATA_OUT;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask

  // Core release is bounded by the watchdog process below
  task automatic core_free;
    n = 0;
    while (CORE_RESET_OUT !== 1'b0)
    begin
      @(posedge CLOCK_IN);
      n++;
    end
  endtask

  task automatic src(input int i, input logic v);
    case (i)
      0: PIN_RESET_N_IN <= !v;
      1: SCAN_RESET_IN <= v;
      default: {USB_ENABLE_IN, USB_RESET_CPU_IN, USB_BUS_RESET_IN} <= {3{v}};
    endcase
  endtask

  task automatic ack;
    WDT_VECTOR_ACK_IN <= 1'b1;
    @(posedge CLOCK_IN);
    WDT_VECTOR_ACK_IN <= 1'b0;
  endtask

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge CLOCK_IN);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN, AWADDR_IN, ARADDR_IN,
     WDATA_IN, WDT_ALWAYS_ON_FUSE_IN, SUPPLY_LOW_IN, SCAN_RESET_IN, USB_ENABLE_IN,
     USB_RESET_CPU_IN, USB_BUS_RESET_IN, COMP_BANDGAP_SEL_IN, ADC_ENABLE_IN,
     WDT_RESTART_IN, WDT_VECTOR_ACK_IN} = '0;
    RST_IN = 1'b1;
    PIN_RESET_N_IN = 1'b1;
    WSTRB_IN = 4'hf;
    BOD_LEVEL_FUSE_IN = 3'h7;
    repeat (20) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    core_free();
    rc(ADDR_CAUSE, 32'h01);
    chk(32'(BOD_ENABLE_OUT), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      {COMP_BANDGAP_SEL_IN, ADC_ENABLE_IN} <= 2'(i);
      repeat (3) @(posedge CLOCK_IN);
      chk(32'(BANDGAP_EN_OUT), 32'(i != 0));
    end
    rd(8'h10);
    chk(32'(rsp), 32'(RESP_ERR));
    // Status register is read-only, so a write is refused
    wr(ADDR_STAT, 32'h0);
    chk(32'(rsp), 32'(RESP_ERR));
    wr(ADDR_CAUSE, 32'h0);
    chk(32'(rsp), 32'(RESP_OK));
    rc(ADDR_CAUSE, 32'h0);
    // Pin, scan and bus reset sources each leave only their own flag
    for (int i = 0; i < 3; i++)
    begin
      src(i, 1'b1);
      repeat (4) @(posedge CLOCK_IN);
      src(i, 1'b0);
      core_free();
      rc(ADDR_CAUSE, src_exp[i]);
      wr(ADDR_CAUSE, 32'h0);
    end
    // Watchdog reset: one-clock pulse, then stretched core reset
    wr(ADDR_WCTL, 32'h08);
    while (WDT_RESET_PULSE_OUT !== 1'b1) @(posedge CLOCK_IN);
    WDT_RESTART_IN <= 1'b1;
    @(posedge CLOCK_IN);
    chk(32'(WDT_RESET_PULSE_OUT), 32'h0);
    chk(32'(CORE_RESET_OUT), 32'h1);
    core_free();
    chk(32'(n inside {[DLY - 2:DLY + 2]}), 32'h1);
    rc(ADDR_CAUSE, 32'h08);
    rc(ADDR_WCTL, 32'h08);
    wr(ADDR_CAUSE, 32'h0);
    rc(ADDR_WCTL, 32'h00);
    // Protected fields: locked writes refused, unlocked ones taken
    wr(ADDR_WCTL, 32'h08);
    wr(ADDR_WCTL, 32'h01);
    rc(ADDR_WCTL, 32'h08);
    wr(ADDR_WCTL, 32'h18);
    wr(ADDR_WCTL, 32'h01);
    rc(ADDR_WCTL, 32'h01);
    wr(ADDR_WCTL, 32'h18);
    repeat (6) @(posedge CLOCK_IN);
    wr(ADDR_WCTL, 32'h00);
    rc(ADDR_WCTL, 32'h09);
    // Interrupt mode: flag and interrupt, no reset
    wr(ADDR_WCTL, 32'h18);
    wr(ADDR_WCTL, 32'h41);
    WDT_RESTART_IN <= 1'b0;
    n = 0;
    while (WDT_IRQ_OUT !== 1'b1)
    begin
      @(posedge CLOCK_IN);
      n++;
    end
    WDT_RESTART_IN <= 1'b1;
    // Prescale step one doubles the shortest time-out; tick phase is unknown
    chk(32'(n inside {[(2 * BASE - 1) * OSC + 3:2 * BASE * OSC + 2]}), 32'h1);
    chk(32'(CORE_RESET_OUT), 32'h0);
    rc(ADDR_WCTL, 32'hc1);
    ack();
    repeat (2) @(posedge CLOCK_IN); // Interrupt line lags the flag by one flop
    chk(32'(WDT_IRQ_OUT), 32'h0);
    // Combined mode: interrupt first, vector entry drops to reset only
    wr(ADDR_WCTL, 32'h48);
    WDT_RESTART_IN <= 1'b0;
    while (WDT_IRQ_OUT !== 1'b1) @(posedge CLOCK_IN);
    chk(32'(CORE_RESET_OUT), 32'h0);
    ack();
    rc(ADDR_WCTL, 32'h09);
    while (WDT_RESET_PULSE_OUT !== 1'b1) @(posedge CLOCK_IN);
    @(posedge CLOCK_IN);
    chk(32'(CORE_RESET_OUT), 32'h1);
    // Second power-up with detector and always-on fuse programmed
    RST_IN <= 1'b1;
    BOD_LEVEL_FUSE_IN <= 3'h3;
    WDT_ALWAYS_ON_FUSE_IN <= 1'b1;
    WDT_RESTART_IN <= 1'b1;
    {COMP_BANDGAP_SEL_IN, ADC_ENABLE_IN} <= 2'h0;
    repeat (20) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    core_free();
    chk(32'(BOD_ENABLE_OUT), 32'h1);
    chk(32'(BOD_LEVEL_OUT), 32'h3);
    chk(32'(BANDGAP_EN_OUT), 32'h1);
    rc(ADDR_CAUSE, 32'h01);
    wr(ADDR_WCTL, 32'h40);
    rc(ADDR_WCTL, 32'h08);
    rc(ADDR_STAT, 32'h0e);
    // Brownout: fast assertion, stretched release
    SUPPLY_LOW_IN <= 1'b1;
    n = 0;
    while (CORE_RESET_OUT !== 1'b1)
    begin
      @(posedge CLOCK_IN);
      n++;
    end
    chk(32'(n <= 4), 32'h1);
    repeat (4) @(posedge CLOCK_IN);
    SUPPLY_LOW_IN <= 1'b0;
    core_free();
    chk(32'(n inside {[DLY:DLY + 4]}), 32'h1);
    rc(ADDR_CAUSE, 32'h05);
    final_report();
  end

endmodule

`default_nettype wire
